/* File: cbwd_defs.vh */
// register offsets, field positions and reset values for the cardbus window decoder
`ifndef CBWD_DEFS_VH
`define CBWD_DEFS_VH
`define CBWD_OFF_LAT_LIMIT  8'h1B
`define CBWD_OFF_MEM0_BASE  8'h1C
`define CBWD_OFF_MEM0_LIMIT 8'h20
`define CBWD_OFF_MEM1_BASE  8'h24
`define CBWD_OFF_MEM1_LIMIT 8'h28
`define CBWD_OFF_IO0_BASE   8'h2C
`define CBWD_OFF_IO0_LIMIT  8'h30
`define CBWD_OFF_IO1_BASE   8'h34
`define CBWD_OFF_IO1_LIMIT  8'h38
`define CBWD_OFF_IRQ_NUM    8'h3C
`define CBWD_RST_LAT_LIMIT  8'h00
`define CBWD_RST_MEM        20'h00000
`define CBWD_RST_IO         14'h0000
`define CBWD_RST_IRQ_NUM    8'hFF
`define CBWD_RST_PREFETCH   1'b1
`define CBWD_MEM_LSB        12
`define CBWD_IO_LSB         2
`define CBWD_IO_MSB         15
`define CBWD_BCTL_PF0_BIT   8
`define CBWD_BCTL_PF1_BIT   9
`define CBWD_GCTL_IOB_BIT   11
`define CBWD_GCTL_IOL_BIT   12
`endif

/* File: cbwd_window_decode.v */
// cardbus window decode, latency limit and interrupt line register
`timescale 1ns/10ps
`include "cbwd_defs.vh"

module cbwd_window_decode (
  input  wire        sys_clk,
  input  wire        rst,
  // configuration access
  input  wire        cfg_wr,
  input  wire        cfg_rd,
  input  wire [7:0]  cfg_addr,
  input  wire [31:0] cfg_wdata,
  output reg  [31:0] cfg_rdata,
  // bridge control and general control bits
  input  wire [15:0] bridge_ctrl_wdata,
  input  wire        bridge_ctrl_wr,
  input  wire        io_base_low_sel,
  input  wire        io_limit_low_sel,
  output reg         window_zero_prefetchable,
  output reg         window_one_prefetchable,
  // address decode
  input  wire        pci_req,
  input  wire        pci_is_io,
  input  wire [31:0] pci_addr,
  input  wire        cb_req,
  input  wire        cb_is_io,
  input  wire [31:0] cb_addr,
  output reg         pci_to_cb_claim,
  output reg         pci_claim_prefetch,
  output reg         cb_to_pci_claim,
  // cardbus initiator timing and assigned interrupt number
  input  wire        cb_clk_tick,
  input  wire        cframe_start,
  input  wire        data_phase_done,
  input  wire        txn_end,
  output reg         latency_expired,
  output reg         force_terminate,
  output reg  [7:0]  assigned_irq_number
);

////////////////////////////////////////////////////////////////////////////////
// register storage

reg  [7:0]  cardbus_latency_limit;
reg  [31:`CBWD_MEM_LSB] mem_base  [0:1];
reg  [31:`CBWD_MEM_LSB] mem_limit [0:1];
reg  [`CBWD_IO_MSB:`CBWD_IO_LSB] io_base  [0:1];
reg  [`CBWD_IO_MSB:`CBWD_IO_LSB] io_limit [0:1];
reg  [7:0]  lat_count;
reg         lat_active;
reg  [31:0] next_rdata;
wire [1:0]  pci_hit;
wire [1:0]  cb_hit;
wire [1:0]  pf_vec;

always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    cardbus_latency_limit    <= `CBWD_RST_LAT_LIMIT;
    assigned_irq_number      <= `CBWD_RST_IRQ_NUM;
    window_zero_prefetchable <= `CBWD_RST_PREFETCH;
    window_one_prefetchable  <= `CBWD_RST_PREFETCH;
    mem_base[0]  <= `CBWD_RST_MEM;
    mem_base[1]  <= `CBWD_RST_MEM;
    mem_limit[0] <= `CBWD_RST_MEM;
    mem_limit[1] <= `CBWD_RST_MEM;
    io_base[0]   <= `CBWD_RST_IO;
    io_base[1]   <= `CBWD_RST_IO;
    io_limit[0]  <= `CBWD_RST_IO;
    io_limit[1]  <= `CBWD_RST_IO;
  end else begin
    if (bridge_ctrl_wr) begin
      window_zero_prefetchable <= bridge_ctrl_wdata[`CBWD_BCTL_PF0_BIT];
      window_one_prefetchable  <= bridge_ctrl_wdata[`CBWD_BCTL_PF1_BIT];
    end
    if (cfg_wr) begin
      case (cfg_addr)
        `CBWD_OFF_LAT_LIMIT:  cardbus_latency_limit <= cfg_wdata[7:0];
        `CBWD_OFF_MEM0_BASE:  mem_base[0]  <= cfg_wdata[31:`CBWD_MEM_LSB];
        `CBWD_OFF_MEM0_LIMIT: mem_limit[0] <= cfg_wdata[31:`CBWD_MEM_LSB];
        `CBWD_OFF_MEM1_BASE:  mem_base[1]  <= cfg_wdata[31:`CBWD_MEM_LSB];
        `CBWD_OFF_MEM1_LIMIT: mem_limit[1] <= cfg_wdata[31:`CBWD_MEM_LSB];
        `CBWD_OFF_IO0_BASE:   io_base[0]   <= cfg_wdata[`CBWD_IO_MSB:`CBWD_IO_LSB];
        `CBWD_OFF_IO0_LIMIT:  io_limit[0]  <= cfg_wdata[`CBWD_IO_MSB:`CBWD_IO_LSB];
        `CBWD_OFF_IO1_BASE:   io_base[1]   <= cfg_wdata[`CBWD_IO_MSB:`CBWD_IO_LSB];
        `CBWD_OFF_IO1_LIMIT:  io_limit[1]  <= cfg_wdata[`CBWD_IO_MSB:`CBWD_IO_LSB];
        `CBWD_OFF_IRQ_NUM:    assigned_irq_number <= cfg_wdata[7:0];
        default: begin
        end
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// read mux

always @* begin
  next_rdata = 32'h00000000;
  case (cfg_addr)
    `CBWD_OFF_LAT_LIMIT:  next_rdata = {24'h000000, cardbus_latency_limit};
    `CBWD_OFF_MEM0_BASE:  next_rdata = {mem_base[0], 12'h000};
    `CBWD_OFF_MEM0_LIMIT: next_rdata = {mem_limit[0], 12'h000};
    `CBWD_OFF_MEM1_BASE:  next_rdata = {mem_base[1], 12'h000};
    `CBWD_OFF_MEM1_LIMIT: next_rdata = {mem_limit[1], 12'h000};
    `CBWD_OFF_IO0_BASE:   next_rdata = {16'h0000, io_base[0], 1'b0, io_base_low_sel};
    `CBWD_OFF_IO0_LIMIT:  next_rdata = {16'h0000, io_limit[0], 1'b0, io_limit_low_sel};
    `CBWD_OFF_IO1_BASE:   next_rdata = {16'h0000, io_base[1], 1'b0, io_base_low_sel};
    `CBWD_OFF_IO1_LIMIT:  next_rdata = {16'h0000, io_limit[1], 1'b0, io_limit_low_sel};
    `CBWD_OFF_IRQ_NUM:    next_rdata = {24'h000000, assigned_irq_number};
    default:              next_rdata = 32'h00000000;
  endcase
end

always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    cfg_rdata <= 32'h00000000;
  end else if (cfg_rd) begin
    cfg_rdata <= next_rdata;
  end
end

////////////////////////////////////////////////////////////////////////////////
// window compare, one per window

assign pf_vec = {window_one_prefetchable, window_zero_prefetchable};

genvar gi;
generate
  for (gi = 0; gi < 2; gi = gi + 1) begin : g_win
    wire mem_en;
    wire io_en;
    wire pci_mem_hit;
    wire cb_mem_hit;
    wire pci_io_hit;
    wire cb_io_hit;
    assign mem_en = (mem_base[gi] != 20'h00000) || (mem_limit[gi] != 20'h00000);
    assign io_en  = (io_base[gi] != 14'h0000) || (io_limit[gi] != 14'h0000);
    assign pci_mem_hit = mem_en &&
      (pci_addr[31:`CBWD_MEM_LSB] >= mem_base[gi]) &&
      (pci_addr[31:`CBWD_MEM_LSB] <= mem_limit[gi]);
    assign cb_mem_hit = mem_en &&
      (cb_addr[31:`CBWD_MEM_LSB] >= mem_base[gi]) &&
      (cb_addr[31:`CBWD_MEM_LSB] <= mem_limit[gi]);
    assign pci_io_hit = io_en && (pci_addr[31:16] == 16'h0000) &&
      (pci_addr[`CBWD_IO_MSB:`CBWD_IO_LSB] >= io_base[gi]) &&
      (pci_addr[`CBWD_IO_MSB:`CBWD_IO_LSB] <= io_limit[gi]);
    assign cb_io_hit = io_en && (cb_addr[31:16] == 16'h0000) &&
      (cb_addr[`CBWD_IO_MSB:`CBWD_IO_LSB] >= io_base[gi]) &&
      (cb_addr[`CBWD_IO_MSB:`CBWD_IO_LSB] <= io_limit[gi]);
    assign pci_hit[gi] = pci_is_io ? pci_io_hit : pci_mem_hit;
    assign cb_hit[gi]  = cb_is_io ? cb_io_hit : cb_mem_hit;
  end
endgenerate

// pci hits go to cardbus, cardbus cycles inside a window go to pci
always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    pci_to_cb_claim    <= 1'b0;
    pci_claim_prefetch <= 1'b0;
    cb_to_pci_claim    <= 1'b0;
  end else begin
    pci_to_cb_claim    <= pci_req && (pci_hit != 2'b00);
    pci_claim_prefetch <= pci_req && !pci_is_io && ((pci_hit & pf_vec) != 2'b00);
    cb_to_pci_claim    <= cb_req && (cb_hit != 2'b00);
  end
end

////////////////////////////////////////////////////////////////////////////////
// latency timer

always @(posedge sys_clk or posedge rst) begin
  if (rst) begin
    lat_count       <= 8'h00;
    lat_active      <= 1'b0;
    latency_expired <= 1'b0;
    force_terminate <= 1'b0;
  end else if (cframe_start) begin
    lat_count       <= 8'h00;
    lat_active      <= 1'b1;
    latency_expired <= 1'b0;
    force_terminate <= 1'b0;
  end else if (txn_end) begin
    lat_active      <= 1'b0;
    latency_expired <= 1'b0;
    force_terminate <= 1'b0;
  end else if (lat_active) begin
    if (cb_clk_tick && !latency_expired) begin
      lat_count <= lat_count + 8'h01;
      if (lat_count + 8'h01 >= cardbus_latency_limit) begin
        latency_expired <= 1'b1;
      end
    end
    if (latency_expired && data_phase_done) begin
      force_terminate <= 1'b1;
    end
  end
end

endmodule // cbwd_window_decode

/* File: cbwd_card_model.sv */
// card side model: cardbus clock ticks only while a frame runs
`timescale 1ns/10ps
module cbwd_card_model #(parameter DIV = 3) (
  input  wire sys_clk,
  input  wire rst,
  input  wire run,
  output reg  cb_clk_tick
);
  reg [3:0] cnt;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      cb_clk_tick <= 1'b0;
    end else begin
      cnt <= (!run || cnt == DIV - 1) ? 4'h0 : cnt + 4'h1;
      cb_clk_tick <= run && cnt == 4'h0;
    end
  end
endmodule // cbwd_card_model

/* File: cbwd_window_decode_props.sv */
// assertions on the window decoder ports
`timescale 1ns/10ps
module cbwd_checker (
  input wire        sys_clk,
  input wire        rst,
  input wire        cfg_wr,
  input wire [15:0] bridge_ctrl_wdata,
  input wire        bridge_ctrl_wr,
  input wire        pci_req,
  input wire        pci_is_io,
  input wire [31:0] pci_addr,
  input wire        cb_req,
  input wire        cb_clk_tick,
  input wire        cframe_start,
  input wire        data_phase_done,
  input wire        window_zero_prefetchable,
  input wire        window_one_prefetchable,
  input wire        pci_to_cb_claim,
  input wire        cb_to_pci_claim,
  input wire        latency_expired,
  input wire        force_terminate,
  input wire [7:0]  assigned_irq_number
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_pf0_load: assert property (
    bridge_ctrl_wr |=> window_zero_prefetchable == $past(bridge_ctrl_wdata[8]))
    else $error("prefetch flag not loaded");
  a_pf_hold: assert property (
    !bridge_ctrl_wr |=> $stable({window_zero_prefetchable, window_one_prefetchable}))
    else $error("prefetch flag moved");
  a_term_cause: assert property (
    $rose(force_terminate) |-> $past(latency_expired) && $past(data_phase_done))
    else $error("terminate without cause");
  a_lat_restart: assert property (
    cframe_start && !cb_clk_tick |=> !latency_expired && !force_terminate)
    else $error("latency not restarted");
  a_io_page: assert property (
    pci_req && pci_is_io && pci_addr[31:16] != 16'h0000 |=> !pci_to_cb_claim)
    else $error("io claim above first page");
  a_claim_idle: assert property (
    !pci_req |=> !pci_to_cb_claim) else $error("claim without request");
  a_cb_idle: assert property (
    !cb_req |=> !cb_to_pci_claim) else $error("upstream claim without request");
  a_irq_hold: assert property (
    !cfg_wr |=> $stable(assigned_irq_number)) else $error("irq number moved");
  c_term: cover property (force_terminate);
  c_down: cover property (pci_to_cb_claim);
  c_up: cover property (cb_to_pci_claim);
endmodule // cbwd_checker
bind cbwd_window_decode cbwd_checker u_chk (.*);

/* File: cbwd_window_decode_tb.sv */
// self-checking bench for the cardbus window decoder
`timescale 1ns/10ps
`include "cbwd_defs.vh"
module cbwd_window_decode_tb;
  reg sys_clk = 1'b0, rst, cfg_wr, cfg_rd, bridge_ctrl_wr, io_base_low_sel, io_limit_low_sel;
  reg pci_req, pci_is_io, cb_req, cb_is_io, cframe_start, data_phase_done, txn_end, run;
  reg [7:0] cfg_addr;
  reg [31:0] cfg_wdata, pci_addr, cb_addr;
  reg [15:0] bridge_ctrl_wdata;
  wire [31:0] cfg_rdata;
  wire [7:0] assigned_irq_number;
  wire window_zero_prefetchable, window_one_prefetchable, pci_to_cb_claim, pci_claim_prefetch;
  wire cb_to_pci_claim, cb_clk_tick, latency_expired, force_terminate;
  integer bad_count, checked, n, w;
  cbwd_window_decode dut (.*);
  cbwd_card_model #(.DIV(3)) card (.sys_clk(sys_clk), .rst(rst), .run(run),
    .cb_clk_tick(cb_clk_tick));
  always #12.5 sys_clk = ~sys_clk;
  task complete_run;
    begin
      if (bad_count == 0 && checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      cfg_addr = a;
      cfg_wdata = d;
      cfg_wr = 1'b1;
      @(posedge sys_clk) #1;
      cfg_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      cfg_addr = a;
      cfg_rd = 1'b1;
      @(posedge sys_clk) #1;
      cfg_rd = 1'b0;
      chk(cfg_rdata, e);
    end
  endtask
  // side 0 asks from the host bus, side 1 from the card bus
  task dec(input io, input [31:0] a, input side, input e);
    begin
      {pci_is_io, cb_is_io, pci_addr, cb_addr} = {io, io, a, a};
      {pci_req, cb_req} = {!side, side};
      @(posedge sys_clk) #1;
      {pci_req, cb_req} = 2'b00;
      chk(side ? cb_to_pci_claim : pci_to_cb_claim, {31'h0, e});
    end
  endtask
  initial begin
    {cfg_wr, cfg_rd, bridge_ctrl_wr, io_base_low_sel, io_limit_low_sel, pci_req, pci_is_io} = 0;
    {cb_req, cb_is_io, cframe_start, data_phase_done, txn_end, run, cfg_addr} = 0;
    {cfg_wdata, pci_addr, cb_addr, bridge_ctrl_wdata} = 0;
    {rst, bad_count, checked} = {1'b1, 64'h0};
    repeat (10) @(posedge sys_clk);
    #1 rst = 1'b0;
    chk({window_zero_prefetchable, window_one_prefetchable}, 32'h3);
    rd(`CBWD_OFF_LAT_LIMIT, 32'h0);
    rd(`CBWD_OFF_MEM1_LIMIT, 32'h0);
    rd(`CBWD_OFF_IRQ_NUM, 32'hFF);
    rd(8'h40, 32'h0);
    dec(0, 32'h0, 0, 0);
    dec(1, 32'h0, 0, 0);
    wr(`CBWD_OFF_MEM0_BASE, 32'hFFFFFFFF);
    rd(`CBWD_OFF_MEM0_BASE, 32'hFFFFF000);
    wr(`CBWD_OFF_MEM0_BASE, 32'h00100ABC);
    wr(`CBWD_OFF_MEM0_LIMIT, 32'h00100FFF);
    rd(`CBWD_OFF_MEM0_LIMIT, 32'h00100000);
    dec(0, 32'h00100FFC, 0, 1);
    chk(pci_claim_prefetch, 32'h1);
    dec(0, 32'h00101000, 0, 0);
    dec(0, 32'h000FFFFC, 0, 0);
    dec(0, 32'h00100000, 1, 1);
    bridge_ctrl_wdata = 16'h0200;
    bridge_ctrl_wr = 1'b1;
    @(posedge sys_clk) #1;
    bridge_ctrl_wr = 1'b0;
    chk({window_zero_prefetchable, window_one_prefetchable}, 32'h1);
    dec(0, 32'h00100000, 0, 1);
    chk(pci_claim_prefetch, 32'h0);
    io_base_low_sel = 1'b1;
    wr(`CBWD_OFF_IO0_BASE, 32'hFFFFFFFF);
    rd(`CBWD_OFF_IO0_BASE, 32'h0000FFFD);
    wr(`CBWD_OFF_IO0_BASE, 32'h00001000);
    wr(`CBWD_OFF_IO0_LIMIT, 32'hFFFF1FFF);
    rd(`CBWD_OFF_IO0_LIMIT, 32'h00001FFC);
    io_limit_low_sel = 1'b1;
    rd(`CBWD_OFF_IO0_LIMIT, 32'h00001FFD);
    dec(1, 32'h00001FFC, 0, 1);
    dec(1, 32'h00002000, 0, 0);
    dec(1, 32'h00011000, 0, 0);
    dec(1, 32'h00001000, 1, 1);
    wr(`CBWD_OFF_IRQ_NUM, 32'h5A);
    rd(`CBWD_OFF_IRQ_NUM, 32'h5A);
    wr(`CBWD_OFF_LAT_LIMIT, 32'hFFFFFF20);
    rd(`CBWD_OFF_LAT_LIMIT, 32'h20);
    wr(`CBWD_OFF_LAT_LIMIT, 32'h02);
    {cframe_start, run} = 2'b11;
    @(posedge sys_clk) #1;
    {cframe_start, n, w} = 0;
    while (!latency_expired && w < 40) begin
      n = n + cb_clk_tick;
      w = w + 1;
      @(posedge sys_clk) #1;
    end
    if (w >= 40) begin
      bad_count = bad_count + 1;
      complete_run;
    end
    chk(n, 32'h2);
    chk(force_terminate, 32'h0);
    data_phase_done = 1'b1;
    @(posedge sys_clk) #1;
    data_phase_done = 1'b0;
    chk(force_terminate, 32'h1);
    {txn_end, run} = 2'b10;
    @(posedge sys_clk) #1;
    txn_end = 1'b0;
    chk({latency_expired, force_terminate}, 32'h0);
    complete_run;
  end
endmodule // cbwd_window_decode_tb
